// ===== src/pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter per lane
// Assumes: lanes are unrelated slow levels
// Notes:   stage one feeds stage two only
module pin_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  pin_sync_if.dst  pins
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_lane
      logic s1;
      logic s2;
      logic s3;
      logic q;
      logic next_q;
      // a change counts once stages two and three agree
      always_comb
      begin
        next_q = (s2 == s3) ? s3 : q;
      end
      // stage registers
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1 <= RST[i];
          s2 <= RST[i];
          s3 <= RST[i];
          q  <= RST[i];
        end
        else
        begin
          s1 <= pins.raw[i];
          s2 <= s1;
          s3 <= s2;
          q  <= next_q;
        end
      end
      assign pins.clean[i] = q;
    end
  endgenerate
endmodule

// ===== src/pin_sync_if.sv
// Purpose: carries raw pin levels in and cleaned levels out
// Assumes: one bit per lane
// Notes:   none
interface pin_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport src (output raw, input clean);
  modport dst (input raw, output clean);
endinterface

// ===== src/pmr_pkg.sv
// Purpose: shared constants and types of the power mode and reset controller
// Assumes: 8-bit registers on a 4-bit word address
// Notes:   bit positions are for the register mux and the core-side decode
package pmr_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 11;
  localparam int SYNC_W = 14;

  // register addresses
  localparam logic [ADDR_W-1:0] POWER_CONTROL_REG_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] AUX1_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] AUX_ADDR  = 4'h2;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 4'h3;

  // power_control_reg fields
  localparam int IDLE_BIT = 0;
  localparam int PD_BIT   = 1;
  localparam int POF_BIT  = 4;
  localparam int BOF_BIT  = 5;
  // aux_control_reg fields
  localparam int BOI_BIT  = 5;
  localparam int BOD_BIT  = 6;
  // aux_register fields
  localparam int LVM_BIT  = 4;

  // reset values
  localparam logic POWER_CONTROL_REG_FLAG_RST = 1'b0;
  localparam logic AUX1_BIT_RST  = 1'b0;
  localparam logic LVM_RST       = 1'b0;

  // oscillator stability waits, in cpu clocks
  localparam logic [CNT_W-1:0] XTAL_STARTUP_CLKS = 11'h400;
  localparam logic [CNT_W-1:0] RC_STARTUP_CLKS   = 11'h100;

  // synchroniser lane order and reset levels
  localparam int S_BELOW_LO = 0;
  localparam int S_BELOW_HI = 1;
  localparam int S_POR      = 2;
  localparam int S_RST_PIN  = 3;
  localparam int S_EXT0     = 4;
  localparam int S_EXT1     = 5;
  localparam int S_KBD      = 6;
  localparam int S_CMP      = 7;
  localparam int S_WDT_OVF  = 8;
  localparam int S_WDT_IRQ  = 9;
  localparam int S_LVL_SEL  = 10;
  localparam int S_WATCHDOG_ENABLE_CFG     = 11;
  localparam int S_RPD      = 12;
  localparam int S_XTAL     = 13;
  localparam logic [SYNC_W-1:0] SYNC_RST = 14'h1408;

  typedef enum logic [1:0]
  {
    ST_RUN   = 2'b00,
    ST_IDLE  = 2'b01,
    ST_PDOWN = 2'b10,
    ST_START = 2'b11
  } pm_state_type;
endpackage

// ===== src/power_mode_reset_ctrl.sv
// Purpose: brownout, power-on flag, idle and power down, wake-up and reset control
// Assumes: core_clk keeps running; osc_enable models the main oscillator gate
// Notes:   core-side enables and priority arrive on core_clk, pins are synchronised

// Operation
// - level select 1 picks 2.5 V, 0 3.8 V
// - disable bit silences brownout reset and interrupt
// - power-on detect sets sticky power-on flag
// - idle request stops cpu, irq or reset ends
// - power-down request enters power down, oscillator stops
// - power down ends on reset or higher-priority wake
// - wake restarts oscillator, waits 1024 or 256 clocks
// - watchdog overflow resets even in power down
// - brownout reset acts at once, even powered down
// - brownout interrupt wakes from power down
// - brownout, watchdog, comparators keep running in power down
// - external, keyboard, comparator wake need their enables
// - watchdog wakes by reset or interrupt per config
// - brownout wakes only when not disabled, per select
// - reset pin wakes only when pin enabled
// - low-voltage memory bit cleared only by power-on
// - reset pin active low, config 0 disables it
// - brownout reset held while low, else one interrupt
// - brownout sets sticky brownout flag
module power_mode_reset_ctrl (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic [pmr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [pmr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output      logic [pmr_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                       supply_below_2v5,
  input  wire logic                       supply_below_3v8,
  input  wire logic                       power_on_detect,
  input  wire logic                       ext_reset_pin_n,
  input  wire logic                       ext_int0,
  input  wire logic                       ext_int1,
  input  wire logic                       kbd_wake,
  input  wire logic                       cmp_wake,
  input  wire logic                       wdt_overflow,
  input  wire logic                       wdt_irq,
  input  wire logic                       brownout_level_select,
  input  wire logic                       watchdog_enable_cfg,
  input  wire logic                       reset_pin_disable_cfg,
  input  wire logic                       crystal_osc_cfg,
  input  wire logic                       ex0_irq_en,
  input  wire logic                       ex1_irq_en,
  input  wire logic                       kbd_feature_en,
  input  wire logic                       kbd_irq_en,
  input  wire logic                       cmp_feature_en,
  input  wire logic                       cmp_irq_en,
  input  wire logic                       wdt_irq_en,
  input  wire logic                       brownout_irq_enable,
  input  wire logic                       any_enabled_irq,
  input  wire logic                       wake_prio_ok,
  output      logic                       cpu_reset,
  output      logic                       cpu_run,
  output      logic                       osc_enable,
  output      logic                       brownout_irq,
  output      logic                       mem_hv_off
);
  logic                        rst_s1;
  logic                        rst_s;
  pin_sync_if #(.W(pmr_pkg::SYNC_W)) sync_pins ();
  logic [pmr_pkg::SYNC_W-1:0]  pin;
  pmr_pkg::pm_state_type       state;
  pmr_pkg::pm_state_type       next_state;
  logic [pmr_pkg::CNT_W-1:0]   count;
  logic [pmr_pkg::CNT_W-1:0]   next_count;
  logic                        idle_request;
  logic                        power_down_request;
  logic                        power_on_flag;
  logic                        brownout_flag;
  logic                        brownout_irq_select;
  logic                        brownout_disable;
  logic                        low_voltage_memory_mode;
  logic                        next_idle_request;
  logic                        next_power_down_request;
  logic                        next_power_on_flag;
  logic                        next_brownout_flag;
  logic                        next_brownout_irq_select;
  logic                        next_brownout_disable;
  logic                        next_low_voltage_memory_mode;
  logic                        bo_active_d;
  logic                        wdt_ovf_d;
  logic                        next_cpu_reset;
  logic                        next_cpu_run;
  logic                        next_osc_enable;
  logic                        next_brownout_irq;
  logic [pmr_pkg::DATA_W-1:0]  next_reg_rdata;
  logic                        bo_below;
  logic                        bo_active;
  logic                        bo_reset;
  logic                        bo_irq_evt;
  logic                        wdt_reset;
  logic                        pin_reset;
  logic                        reset_req;
  logic                        irq_wake;
  logic                        wr_power_control_reg;
  logic [pmr_pkg::CNT_W-1:0]   wait_len;

  // reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1 <= 1'b0;
      rst_s  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s  <= rst_s1;
    end
  end

  // pins from the supply monitor, reset pin, wake sources, watchdog oscillator and straps
  assign sync_pins.raw = {crystal_osc_cfg, reset_pin_disable_cfg, watchdog_enable_cfg,
                          brownout_level_select, wdt_irq, wdt_overflow, cmp_wake, kbd_wake,
                          ext_int1, ext_int0, ext_reset_pin_n, power_on_detect,
                          supply_below_3v8, supply_below_2v5};
  pin_sync #(
    .W   (pmr_pkg::SYNC_W),
    .RST (pmr_pkg::SYNC_RST)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_s),
    .pins     (sync_pins.dst)
  );
  assign pin = sync_pins.clean;

  // event sources; none of them look at the power state
  always_comb
  begin
    bo_below   = pin[pmr_pkg::S_LVL_SEL] ? pin[pmr_pkg::S_BELOW_LO]
                                         : pin[pmr_pkg::S_BELOW_HI];
    bo_active  = bo_below & ~brownout_disable;
    bo_reset   = bo_active & ~brownout_irq_select;
    bo_irq_evt = bo_active & ~bo_active_d & brownout_irq_select;
    wdt_reset  = pin[pmr_pkg::S_WDT_OVF] & ~wdt_ovf_d & pin[pmr_pkg::S_WATCHDOG_ENABLE_CFG];
    pin_reset  = ~pin[pmr_pkg::S_RST_PIN] & pin[pmr_pkg::S_RPD];
    reset_req  = bo_reset | wdt_reset | pin_reset;
    irq_wake   = wake_prio_ok & (
                 (pin[pmr_pkg::S_EXT0] & ex0_irq_en) |
                 (pin[pmr_pkg::S_EXT1] & ex1_irq_en) |
                 (pin[pmr_pkg::S_KBD] & kbd_feature_en & kbd_irq_en) |
                 (pin[pmr_pkg::S_CMP] & cmp_feature_en & cmp_irq_en) |
                 (pin[pmr_pkg::S_WDT_IRQ] & ~pin[pmr_pkg::S_WATCHDOG_ENABLE_CFG] & wdt_irq_en) |
                 (bo_irq_evt & brownout_irq_enable));
    wait_len   = pin[pmr_pkg::S_XTAL] ? pmr_pkg::XTAL_STARTUP_CLKS
                                      : pmr_pkg::RC_STARTUP_CLKS;
    wr_power_control_reg    = reg_wr && (reg_addr == pmr_pkg::POWER_CONTROL_REG_ADDR);
  end

  // power state machine and stability counter
  always_comb
  begin
    next_state              = state;
    next_count              = count;
    next_idle_request       = idle_request;
    next_power_down_request = power_down_request;
    next_cpu_reset          = cpu_reset;
    if (wr_power_control_reg)
    begin
      next_idle_request       = reg_wdata[pmr_pkg::IDLE_BIT];
      next_power_down_request = reg_wdata[pmr_pkg::PD_BIT];
    end
    if (reset_req)
    begin
      // any reset restarts the oscillator and holds the core
      next_state              = pmr_pkg::ST_START;
      next_count              = wait_len - 11'h001;
      next_cpu_reset          = 1'b1;
      next_idle_request       = 1'b0;
      next_power_down_request = 1'b0;
    end
    else
    begin
      case (state)
        pmr_pkg::ST_RUN:
        begin
          if (power_down_request)
            next_state = pmr_pkg::ST_PDOWN;
          else if (idle_request)
            next_state = pmr_pkg::ST_IDLE;
        end
        pmr_pkg::ST_IDLE:
        begin
          if (any_enabled_irq)
          begin
            next_state        = pmr_pkg::ST_RUN;
            next_idle_request = 1'b0;
          end
        end
        pmr_pkg::ST_PDOWN:
        begin
          if (irq_wake)
          begin
            next_state              = pmr_pkg::ST_START;
            next_count              = wait_len - 11'h001;
            next_power_down_request = 1'b0;
          end
        end
        pmr_pkg::ST_START:
        begin
          if (count == '0)
          begin
            next_state     = pmr_pkg::ST_RUN;
            next_cpu_reset = 1'b0;
          end
          else
            next_count = count - 11'h001;
        end
        default:
          next_state = pmr_pkg::ST_RUN;
      endcase
    end
    next_cpu_run    = (next_state == pmr_pkg::ST_RUN) && !next_cpu_reset;
    next_osc_enable = (next_state != pmr_pkg::ST_PDOWN);
  end

  // state registers
  always_ff @(posedge core_clk or negedge rst_s)
  begin
    if (!rst_s)
    begin
      state              <= pmr_pkg::ST_RUN;
      count              <= '0;
      idle_request       <= 1'b0;
      power_down_request <= 1'b0;
      cpu_reset          <= 1'b0;
      cpu_run            <= 1'b0;
      osc_enable         <= 1'b1;
    end
    else
    begin
      state              <= next_state;
      count              <= next_count;
      idle_request       <= next_idle_request;
      power_down_request <= next_power_down_request;
      cpu_reset          <= next_cpu_reset;
      cpu_run            <= next_cpu_run;
      osc_enable         <= next_osc_enable;
    end
  end

  // flags, control bits and read mux; hardware set wins over clear
  always_comb
  begin
    next_power_on_flag = (power_on_flag & ~(wr_power_control_reg & ~reg_wdata[pmr_pkg::POF_BIT]))
                         | pin[pmr_pkg::S_POR];
    next_brownout_flag = (brownout_flag & ~(wr_power_control_reg & ~reg_wdata[pmr_pkg::BOF_BIT]))
                         | bo_active;
    next_brownout_irq_select = brownout_irq_select;
    next_brownout_disable    = brownout_disable;
    if (reg_wr && (reg_addr == pmr_pkg::AUX1_ADDR))
    begin
      next_brownout_irq_select = reg_wdata[pmr_pkg::BOI_BIT];
      next_brownout_disable    = reg_wdata[pmr_pkg::BOD_BIT];
    end
    // software may only set it, power-on alone clears it
    next_low_voltage_memory_mode = low_voltage_memory_mode |
      (reg_wr && (reg_addr == pmr_pkg::AUX_ADDR) && reg_wdata[pmr_pkg::LVM_BIT]);
    if (pin[pmr_pkg::S_POR])
      next_low_voltage_memory_mode = 1'b0;
    next_brownout_irq = bo_irq_evt;
    next_reg_rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        pmr_pkg::POWER_CONTROL_REG_ADDR:
        begin
          next_reg_rdata[pmr_pkg::IDLE_BIT] = idle_request;
          next_reg_rdata[pmr_pkg::PD_BIT]   = power_down_request;
          next_reg_rdata[pmr_pkg::POF_BIT]  = power_on_flag;
          next_reg_rdata[pmr_pkg::BOF_BIT]  = brownout_flag;
        end
        pmr_pkg::AUX1_ADDR:
        begin
          next_reg_rdata[pmr_pkg::BOI_BIT] = brownout_irq_select;
          next_reg_rdata[pmr_pkg::BOD_BIT] = brownout_disable;
        end
        pmr_pkg::AUX_ADDR:
          next_reg_rdata[pmr_pkg::LVM_BIT] = low_voltage_memory_mode;
        pmr_pkg::STAT_ADDR:
          next_reg_rdata = {4'h0, bo_active, cpu_reset, state};
        default:
          next_reg_rdata = '0;
      endcase
    end
  end

  // flag and control registers
  always_ff @(posedge core_clk or negedge rst_s)
  begin
    if (!rst_s)
    begin
      power_on_flag           <= pmr_pkg::POWER_CONTROL_REG_FLAG_RST;
      brownout_flag           <= pmr_pkg::POWER_CONTROL_REG_FLAG_RST;
      brownout_irq_select     <= pmr_pkg::AUX1_BIT_RST;
      brownout_disable        <= pmr_pkg::AUX1_BIT_RST;
      low_voltage_memory_mode <= pmr_pkg::LVM_RST;
      bo_active_d             <= 1'b0;
      wdt_ovf_d               <= 1'b0;
      brownout_irq            <= 1'b0;
      mem_hv_off              <= 1'b0;
      reg_rdata               <= '0;
    end
    else
    begin
      power_on_flag           <= next_power_on_flag;
      brownout_flag           <= next_brownout_flag;
      brownout_irq_select     <= next_brownout_irq_select;
      brownout_disable        <= next_brownout_disable;
      low_voltage_memory_mode <= next_low_voltage_memory_mode;
      bo_active_d             <= bo_active;
      wdt_ovf_d               <= pin[pmr_pkg::S_WDT_OVF];
      brownout_irq            <= next_brownout_irq;
      mem_hv_off              <= next_low_voltage_memory_mode;
      reg_rdata               <= next_reg_rdata;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_s);

  // helper: cycles spent in the current wait, cleared by any reset request
  logic [11:0] start_cycles;
  logic [11:0] next_start_cycles;
  always_comb
  begin
    next_start_cycles = (state == pmr_pkg::ST_START && !reset_req)
                        ? start_cycles + 12'h001 : 12'h000;
  end
  // helper counter register
  always_ff @(posedge core_clk or negedge rst_s)
  begin
    if (!rst_s)
      start_cycles <= 12'h000;
    else
      start_cycles <= next_start_cycles;
  end

  sequence wake_from_pdown_s;
    state == pmr_pkg::ST_PDOWN && irq_wake && !reset_req;
  endsequence
  sequence wait_bounded_s;
    start_cycles < 12'h400;
  endsequence

  pdown_osc_off_a: assert property (state == pmr_pkg::ST_PDOWN |-> !osc_enable && !cpu_run)
    else $error("oscillator or cpu running in power down");
  bod_quiet_a: assert property (brownout_disable && $past(brownout_disable) |-> !brownout_irq)
    else $error("brownout interrupt while disabled");
  pof_sticky_a: assert property (power_on_flag && !wr_power_control_reg |=> power_on_flag)
    else $error("power-on flag lost without software clear");
  bof_set_a: assert property (bo_active |=> brownout_flag)
    else $error("brownout flag not set");
  idle_entry_a: assert property (state == pmr_pkg::ST_RUN && idle_request && !power_down_request
                                 && !reset_req |=> state == pmr_pkg::ST_IDLE)
    else $error("idle not entered");
  wake_wait_a: assert property (wake_from_pdown_s |=> osc_enable && !cpu_run)
    else $error("wake-up wait wrong");
  wait_bound_a: assert property (state == pmr_pkg::ST_START |-> wait_bounded_s)
    else $error("oscillator wait longer than allowed");
  start_hold_a: assert property (state == pmr_pkg::ST_START && count != '0 |=> !cpu_run)
    else $error("cpu released before oscillator stable");
  bo_reset_a: assert property (bo_reset |=> cpu_reset && !cpu_run)
    else $error("brownout reset not applied");
  wdt_reset_a: assert property (wdt_reset |=> cpu_reset)
    else $error("watchdog overflow did not reset");
  lvm_keep_a: assert property (mem_hv_off && !pin[pmr_pkg::S_POR] |=> mem_hv_off)
    else $error("memory power-down bit cleared without power-on");
  idle_exit_a: assert property (state == pmr_pkg::ST_IDLE && any_enabled_irq && !reset_req
                                |=> state == pmr_pkg::ST_RUN && !idle_request)
    else $error("idle exit did not clear request");
endmodule

// ===== testbench/core_irq_model.sv
// Purpose: core interrupt system and wake-up side facing the power controller
// Assumes: one brownout interrupt pending at a time
// Notes:   bench drives other requests through irq_req and high_busy
module core_irq_model (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic cpu_run,
  input  wire logic brownout_irq,
  input  wire logic brownout_irq_enable,
  input  wire logic irq_req,
  input  wire logic high_busy,
  output      logic any_enabled_irq,
  output      logic wake_prio_ok,
  output      int   bo_pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bo_pend;

  // pending brownout interrupt, serviced once the core runs again
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bo_pend   <= 1'b0;
      bo_pulses <= 0;
    end
    else if (brownout_irq)
    begin
      bo_pend   <= brownout_irq_enable;
      bo_pulses <= bo_pulses + 1;
    end
    else if (cpu_run)
      bo_pend <= 1'b0;
  end

  // enabled requests; a higher interrupt in service blocks wake-up
  assign any_enabled_irq = irq_req | bo_pend;
  assign wake_prio_ok    = !high_busy;
endmodule

// ===== testbench/tb_top.sv
// Purpose: self-checking bench of the power mode and reset controller
// Assumes: pins settle through the controller's synchroniser within a few clocks
// Notes:   one task per scenario; outputs sampled at the edge, before its updates
`define CHK(a, b) \
  begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, reg_wr, reg_rd, supply_below_2v5, supply_below_3v8;
  logic power_on_detect, ext_reset_pin_n, wdt_overflow, brownout_level_select;
  logic watchdog_enable_cfg, reset_pin_disable_cfg, crystal_osc_cfg, brownout_irq_enable;
  logic irq_req, high_busy, any_enabled_irq, wake_prio_ok, cpu_reset, cpu_run;
  logic osc_enable, brownout_irq, mem_hv_off;
  logic [pmr_pkg::ADDR_W-1:0] reg_addr;
  logic [pmr_pkg::DATA_W-1:0] reg_wdata, reg_rdata, v;
  logic [4:0] wk;
  logic [6:0] en;
  int failures = 0, num_checks = 0, bo_pulses, n, p;

  power_mode_reset_ctrl power_mode_reset_ctrl_i (
    .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .supply_below_2v5, .supply_below_3v8, .power_on_detect, .ext_reset_pin_n,
    .ext_int0(wk[0]), .ext_int1(wk[1]), .kbd_wake(wk[2]), .cmp_wake(wk[3]),
    .wdt_overflow, .wdt_irq(wk[4]), .brownout_level_select, .watchdog_enable_cfg,
    .reset_pin_disable_cfg, .crystal_osc_cfg, .ex0_irq_en(en[0]), .ex1_irq_en(en[1]),
    .kbd_feature_en(en[2]), .kbd_irq_en(en[3]), .cmp_feature_en(en[4]),
    .cmp_irq_en(en[5]), .wdt_irq_en(en[6]), .brownout_irq_enable, .any_enabled_irq,
    .wake_prio_ok, .cpu_reset, .cpu_run, .osc_enable, .brownout_irq, .mem_hv_off);

  core_irq_model core_irq_model_i (.core_clk, .rst_n, .cpu_run, .brownout_irq,
    .brownout_irq_enable, .irq_req, .high_busy, .any_enabled_irq, .wake_prio_ok,
    .bo_pulses);

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  // register bus write and read cycles
  task automatic wr(input logic [pmr_pkg::ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [pmr_pkg::ADDR_W-1:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    v = reg_rdata;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // bounded wait for execution, clocks counted in n
  task automatic wait_run(input int lim);
    n = 0;
    while (cpu_run !== 1'b1 && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask

  // reset values, unmapped place, sticky power-on flag, low-voltage memory bit
  task automatic t_regs();
    for (int a = 0; a < 4; a++)
    begin
      rd(4'(a));
      `CHK(v, 8'h00)
    end
    wr(4'hf, 8'hff);
    rd(4'hf);
    `CHK(v, 8'h00)
    rd(pmr_pkg::AUX1_ADDR);
    `CHK(v, 8'h00)
    wr(pmr_pkg::AUX_ADDR, 8'h10);
    wr(pmr_pkg::AUX_ADDR, 8'h00);
    tick(2);
    `CHK(mem_hv_off, 1'b1)
    power_on_detect <= 1'b1;
    tick(10);
    power_on_detect <= 1'b0;
    tick(10);
    wait_run(2000);
    `CHK(mem_hv_off, 1'b0)
    rd(pmr_pkg::POWER_CONTROL_REG_ADDR);
    `CHK(v[pmr_pkg::POF_BIT], 1'b1)
    wr(pmr_pkg::POWER_CONTROL_REG_ADDR, 8'h00);
    rd(pmr_pkg::POWER_CONTROL_REG_ADDR);
    `CHK(v, 8'h00)
  endtask

  // idle entry and exit by an enabled interrupt
  task automatic t_idle();
    wr(pmr_pkg::POWER_CONTROL_REG_ADDR, 8'h01);
    tick(3);
    `CHK(cpu_run, 1'b0)
    `CHK(osc_enable, 1'b1)
    irq_req <= 1'b1;
    wait_run(2000);
    irq_req <= 1'b0;
    `CHK(cpu_run, 1'b1)
    rd(pmr_pkg::POWER_CONTROL_REG_ADDR);
    `CHK(v[pmr_pkg::IDLE_BIT], 1'b0)
  endtask

  // power down, wake source blocked by one missing enable or by a higher interrupt in service, then wake and wait
  task automatic t_pd(input int src, input int miss, input logic x);
    crystal_osc_cfg <= x;
    high_busy       <= (miss == 7);
    en              <= 7'h7f & ~(7'h01 << miss);
    wr(pmr_pkg::POWER_CONTROL_REG_ADDR, 8'h02);
    tick(4);
    `CHK(osc_enable, 1'b0)
    wk <= 5'h01 << src;
    tick(40);
    `CHK(cpu_run, 1'b0)
    en        <= 7'h7f;
    high_busy <= 1'b0;
    p = 0;
    while (osc_enable !== 1'b1 && p < 20)
    begin
      @(posedge core_clk);
      p++;
    end
    wait_run(2000);
    `CHK(n, x ? 1024 : 256)
    wk <= '0;
    en <= '0;
    rd(pmr_pkg::POWER_CONTROL_REG_ADDR);
    `CHK(v[pmr_pkg::PD_BIT], 1'b0)
  endtask

  // brownout reset in power down, held while low, flag, both levels
  task automatic t_bo_rst();
    wr(pmr_pkg::POWER_CONTROL_REG_ADDR, 8'h02);
    supply_below_3v8 <= 1'b1;
    tick(20);
    `CHK(cpu_reset, 1'b0)
    supply_below_2v5 <= 1'b1;
    tick(8);
    `CHK(cpu_reset, 1'b1)
    tick(300);
    `CHK(cpu_reset, 1'b1)
    supply_below_2v5 <= 1'b0;
    supply_below_3v8 <= 1'b0;
    wait_run(2000);
    `CHK(cpu_reset, 1'b0)
    rd(pmr_pkg::POWER_CONTROL_REG_ADDR);
    `CHK(v[pmr_pkg::BOF_BIT], 1'b1)
    wr(pmr_pkg::POWER_CONTROL_REG_ADDR, 8'h00);
    rd(pmr_pkg::POWER_CONTROL_REG_ADDR);
    `CHK(v, 8'h00)
    brownout_level_select <= 1'b0;
    tick(10);
    supply_below_3v8 <= 1'b1;
    tick(8);
    `CHK(cpu_reset, 1'b1)
    supply_below_3v8      <= 1'b0;
    brownout_level_select <= 1'b1;
    wait_run(2000);
  endtask

  // disabled detector gives neither reset nor interrupt
  task automatic t_bo_dis();
    wr(pmr_pkg::AUX1_ADDR, 8'h60);
    p = bo_pulses;
    supply_below_2v5 <= 1'b1;
    tick(30);
    `CHK(cpu_reset, 1'b0)
    `CHK(bo_pulses, p)
    supply_below_2v5 <= 1'b0;
    tick(10);
  endtask

  // brownout interrupt wakes power down, one pulse per crossing
  task automatic t_bo_irq();
    wr(pmr_pkg::AUX1_ADDR, 8'h20);
    brownout_irq_enable <= 1'b1;
    wr(pmr_pkg::POWER_CONTROL_REG_ADDR, 8'h02);
    tick(4);
    p = bo_pulses;
    supply_below_2v5 <= 1'b1;
    wait_run(2000);
    `CHK(cpu_run, 1'b1)
    tick(50);
    `CHK(bo_pulses - p, 1)
    `CHK(cpu_reset, 1'b0)
    supply_below_2v5    <= 1'b0;
    brownout_irq_enable <= 1'b0;
    wr(pmr_pkg::AUX1_ADDR, 8'h00);
  endtask

  // reset pin enabled and disabled, watchdog overflow in power down
  task automatic t_pin();
    ext_reset_pin_n <= 1'b0;
    tick(8);
    `CHK(cpu_reset, 1'b1)
    ext_reset_pin_n <= 1'b1;
    wait_run(2000);
    reset_pin_disable_cfg <= 1'b0;
    watchdog_enable_cfg   <= 1'b1;
    wr(pmr_pkg::POWER_CONTROL_REG_ADDR, 8'h02);
    ext_reset_pin_n <= 1'b0;
    tick(40);
    `CHK(cpu_reset, 1'b0)
    ext_reset_pin_n <= 1'b1;
    wdt_overflow    <= 1'b1;
    tick(8);
    `CHK(cpu_reset, 1'b1)
    wdt_overflow <= 1'b0;
    wait_run(2000);
    `CHK(cpu_reset, 1'b0)
    watchdog_enable_cfg   <= 1'b0;
    reset_pin_disable_cfg <= 1'b1;
    tick(10);
    wdt_overflow <= 1'b1;
    tick(10);
    `CHK(cpu_reset, 1'b0)
    wdt_overflow <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    core_clk = 1'b0;
    {reg_wr, reg_rd, supply_below_2v5, supply_below_3v8, power_on_detect} = '0;
    {wdt_overflow, watchdog_enable_cfg, brownout_irq_enable, irq_req, high_busy} = '0;
    {ext_reset_pin_n, brownout_level_select, reset_pin_disable_cfg, crystal_osc_cfg} = '1;
    rst_n     = 1'b0;
    reg_addr  = '0;
    reg_wdata = '0;
    wk        = '0;
    en        = '0;
    tick(20);
    rst_n <= 1'b1;
    tick(10);
    t_regs();
    t_idle();
    t_pd(0, 0, 1'b1);
    t_pd(1, 1, 1'b0);
    t_pd(2, 2, 1'b1);
    t_pd(3, 5, 1'b0);
    t_pd(4, 6, 1'b1);
    t_pd(0, 7, 1'b0);
    t_bo_rst();
    t_bo_dis();
    t_bo_irq();
    t_pin();
    end_of_test();
  end

  // cuts a hang short
  initial
  begin
    #800000;
    failures++;
    end_of_test();
  end
endmodule
